/* rtl/rate_mux_pkg.sv */
// rate_mux_pkg: shared constants for the double-rate sample multiplexer
// assumes a 32-bit APB register port, 24-bit samples, two 8-slot optical ports
package rate_mux_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CS_TX  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CS_RX  = 12'h00C;
  localparam int SAMPLE_W   = 24;
  localparam int SLOTS      = 8;
  localparam int WORDS      = 16;
  localparam int FRAME_BITS = SLOTS * SAMPLE_W;
  localparam logic [7:0] CNT_LAST   = 8'(FRAME_BITS - 1);
  localparam logic [7:0] CNT_HALF   = 8'(FRAME_BITS / 2);
  localparam logic [7:0] RX_CAPTURE = 8'h03;
  localparam logic [7:0] MAX_CHAN   = 8'h30;
  localparam logic [2:0] LAST_CHAN  = 3'h7;
  localparam logic [3:0] LAST_WORD_DBL = 4'hF;
  localparam logic [3:0] LAST_WORD_SGL = 4'h7;
  // control register fields
  localparam int CTRL_RATE     = 0;
  localparam int CTRL_BASE48   = 2;
  localparam int CTRL_AES_DUAL = 3;
  localparam int CTRL_CHAN     = 4;
  localparam logic [5:0] CHAN_REQ_RST = 6'h08;
  localparam logic [7:0] CS_TX_RST    = 8'h00;
  // status register fields
  localparam int STAT_RATE     = 0;
  localparam int STAT_OPT_ON   = 2;
  localparam int STAT_SINGLE_W = 3;
  localparam int STAT_CHAN     = 4;
  localparam int STAT_CAP      = 12;
  localparam int STAT_OVERRUN  = 13;
  localparam int STAT_BASE48   = 14;
  // channel-status byte 0 fields
  localparam int CS_PRO       = 0;
  localparam int CS_NONAUDIO  = 1;
  localparam int CS_PRO_EMPH  = 2;
  localparam int CS_PRO_LOCK  = 5;
  localparam int CS_CON_COPY  = 2;
  localparam int CS_CON_EMPH  = 3;
  localparam int CS_TOP       = 6;
  // decoded channel-status read-back fields
  localparam int DEC_PRO      = 0;
  localparam int DEC_NONAUDIO = 1;
  localparam int DEC_EMPH     = 2;
  localparam int DEC_LOCK     = 5;
  localparam int DEC_COPY     = 6;
  localparam int DEC_FS       = 8;
  localparam int DEC_MODE     = 10;

  typedef enum logic [1:0] {RATE_SINGLE, RATE_DOUBLE, RATE_QUAD} rate_e;
  typedef logic [WORDS-1:0][SAMPLE_W-1:0] frame_t;

  // the unused code reads as single rate
  function automatic rate_e rate_of(input logic [1:0] code);
    rate_e r;
    r = RATE_SINGLE;
    if (code == 2'h1)
    begin
      r = RATE_DOUBLE;
    end
    else if (code == 2'h2)
    begin
      r = RATE_QUAD;
    end
    return r;
  endfunction
endpackage

/* rtl/split_channel_link.sv */
// split_channel_link: optical port framing on the recovered link clock
// assumes tx_frame_in is held stable while tx_req_in differs from tx_ack_out
`timescale 1ns/10ps
`default_nettype none
module split_channel_link
  import rate_mux_pkg::*;
(
  input  wire logic link_clk_in,
  input  wire logic srst_in,
  input  wire logic tx_req_in,
  input  wire logic quad_in,
  input  wire logic double_in,
  input  wire frame_t tx_frame_in,
  input  wire logic opt_first_rx_in,
  input  wire logic opt_second_rx_in,
  output logic      tx_ack_out,
  output logic      rx_tgl_out,
  output logic      tick_tgl_out,
  output frame_t    rx_frame_out,
  output logic      opt_first_tx_out,
  output logic      opt_second_tx_out,
  output logic      opt_frame_out
);
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic [7:0] cnt_ff;
  logic [FRAME_BITS-1:0] sh1_ff;
  logic [FRAME_BITS-1:0] sh2_ff;
  logic [FRAME_BITS-1:0] rsh1_ff;
  logic [FRAME_BITS-1:0] rsh2_ff;
  logic [FRAME_BITS-1:0] port1_bits;
  logic [FRAME_BITS-1:0] port2_bits;
  logic rst;
  logic quad;
  logic load_new;

  always_ff @(posedge link_clk_in)
  begin
    sync1_ff <= {srst_in, tx_req_in, quad_in, double_in, opt_first_rx_in, opt_second_rx_in};
    sync2_ff <= sync1_ff;
  end

  assign rst      = sync2_ff[5];
  assign quad     = sync2_ff[3];
  assign load_new = (cnt_ff == 8'h00) && (sync2_ff[4] != tx_ack_out);
  // each port carries eight words as one flat lsb-first bit string
  assign port1_bits = tx_frame_in[SLOTS-1:0];
  assign port2_bits = tx_frame_in[WORDS-1:SLOTS];

  // frame counter runs at single rate whatever the sample rate
  always_ff @(posedge link_clk_in)
  begin
    if (rst || cnt_ff == CNT_LAST)
      cnt_ff <= 8'h00; // RULE6
    else
      cnt_ff <= cnt_ff + 8'h01;
  end

  // converters and transmitters share this clock; double rate ticks twice a frame
  always_ff @(posedge link_clk_in)
  begin
    if (rst)
      tick_tgl_out <= 1'b0;
    else if (cnt_ff == 8'h00 || (sync2_ff[2] && cnt_ff == CNT_HALF))
      tick_tgl_out <= ~tick_tgl_out; // RULE1 RULE12
  end

  always_ff @(posedge link_clk_in)
  begin
    if (rst)
      tx_ack_out <= 1'b0;
    else if (load_new)
      tx_ack_out <= sync2_ff[4];
  end

  // slot 0 first, each word lsb first; no new frame sends silence
  always_ff @(posedge link_clk_in)
  begin
    if (rst || quad)
    begin
      sh1_ff            <= '0;
      sh2_ff            <= '0;
      opt_first_tx_out  <= 1'b0; // RULE7
      opt_second_tx_out <= 1'b0;
      opt_frame_out     <= 1'b0;
    end
    else if (cnt_ff == 8'h00)
    begin
      sh1_ff            <= load_new ? {1'b0, port1_bits[FRAME_BITS-1:1]} : '0; // RULE4
      sh2_ff            <= load_new ? {1'b0, port2_bits[FRAME_BITS-1:1]} : '0;
      opt_first_tx_out  <= load_new & tx_frame_in[0][0];
      opt_second_tx_out <= load_new & tx_frame_in[SLOTS][0];
      opt_frame_out     <= 1'b1; // RULE6
    end
    else
    begin
      sh1_ff            <= {1'b0, sh1_ff[FRAME_BITS-1:1]};
      sh2_ff            <= {1'b0, sh2_ff[FRAME_BITS-1:1]};
      opt_first_tx_out  <= sh1_ff[0];
      opt_second_tx_out <= sh2_ff[0];
      opt_frame_out     <= 1'b0;
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    rsh1_ff <= {sync2_ff[1], rsh1_ff[FRAME_BITS-1:1]};
    rsh2_ff <= {sync2_ff[0], rsh2_ff[FRAME_BITS-1:1]};
    if (rst)
      rx_tgl_out <= 1'b0;
    else if (!quad && cnt_ff == RX_CAPTURE)
    begin
      rx_frame_out <= {rsh2_ff, rsh1_ff}; // RULE13
      rx_tgl_out   <= ~rx_tgl_out;
    end
  end

  a_frame_period : assert property (@(posedge link_clk_in) disable iff (rst) // RULE6
    opt_frame_out |-> ##192 (opt_frame_out || quad))
    else $error("optical frame spacing is not one single-rate frame");
  a_quad_dark : assert property (@(posedge link_clk_in) disable iff (rst) // RULE7
    quad |=> !opt_first_tx_out && !opt_second_tx_out && !opt_frame_out)
    else $error("optical output active at quad rate");
  a_double_tick : assert property (@(posedge link_clk_in) disable iff (rst) // RULE1
    (sync2_ff[2] && cnt_ff == CNT_HALF) |=> tick_tgl_out != $past(tick_tgl_out))
    else $error("missing mid-frame sample tick at double rate");
endmodule
`default_nettype wire

/* rtl/double_rate_sample_multiplexer.sv */
// double_rate_sample_multiplexer: rate modes, split-channel mapping, channel status
// assumes an APB master on sys_clk_in and a free-running recovered link clock
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RULE1 - double rate doubles the converter sample tick
// RULE2 - samples stay 24 bits at double rate
// RULE3 - even samples one slot, odd samples paired slot
// RULE4 - double rate always splits channels on optical ports
// RULE5 - inputs 1-4 first port, 5-8 second port
// RULE6 - optical frames stay at single rate
// RULE7 - no optical output at quad; cap at 48
// RULE8 - quad rate AES output is single wire only
// RULE9 - byte 0 bit 0 selects pro or consumer
// RULE10 - decode byte 0 fields per selected layout
// RULE11 - sample position independent of status format
// RULE12 - recovered clock drives converters and transmitters
// RULE13 - receive re-interleaves slot pairs in send order
module double_rate_sample_multiplexer
  import rate_mux_pkg::*;
(
  input  wire logic                sys_clk_in,
  input  wire logic                srst_in,
  input  wire logic                link_clk_in,
  input  wire logic [ADDR_W-1:0]   paddr_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [31:0]         pwdata_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  input  wire logic                tx_valid_in,
  input  wire logic [2:0]          tx_chan_in,
  input  wire logic [SAMPLE_W-1:0] tx_sample_in,
  output logic                     rx_valid_out,
  output logic      [2:0]          rx_chan_out,
  output logic      [SAMPLE_W-1:0] rx_sample_out,
  output logic                     aes_valid_out,
  output logic      [SAMPLE_W-1:0] aes_sample_out,
  output logic      [7:0]          cs_tx_byte0_out,
  output logic                     aes_dual_wire_out,
  input  wire logic [7:0]          cs_rx_in,
  output logic                     conv_tick_out,
  input  wire logic                opt_first_rx_in,
  input  wire logic                opt_second_rx_in,
  output logic                     opt_first_tx_out,
  output logic                     opt_second_tx_out,
  output logic                     opt_frame_out
);
  logic [1:0]  rate_sel_ff;
  logic        base48_ff;
  logic        aes_dual_req_ff;
  logic [5:0]  chan_req_ff;
  logic [7:0]  chan_count_ff;
  logic        cap_hit_ff;
  logic        overrun_ff;
  logic [11:0] cs_dec_ff;
  logic [11:0] nxt_cs_dec;
  logic [7:0]  nxt_load;
  logic [7:0]  tx_par_ff;
  frame_t      tx_work_ff;
  frame_t      tx_hold_ff;
  logic        tx_req_ff;
  logic [2:0]  sync1_ff;
  logic [2:0]  sync2_ff;
  logic [1:0]  sync3_ff;
  logic        rx_busy_ff;
  logic        rx_odd_ff;
  logic [3:0]  rx_ptr_ff;
  frame_t      link_rx_frame;
  logic        link_ack;
  logic        link_rx_tgl;
  logic        link_tick_tgl;
  rate_e       rate;
  logic        dbl;
  logic        quad;
  logic        par_sel;
  logic [3:0]  tx_idx;
  logic        frame_done;
  logic        apb_acc;
  logic        apb_wr;
  logic [31:0] status_word;

  // register decode used by the error answer; the read path decodes with its own case
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_CS_TX) || (a == OFS_CS_RX);
  endfunction

  assign rate       = rate_of(rate_sel_ff);
  assign dbl        = (rate == RATE_DOUBLE);
  assign quad       = (rate == RATE_QUAD);
  assign apb_acc    = psel_in & penable_in;
  assign apb_wr     = apb_acc & pready_out & pwrite_in;
  assign par_sel    = tx_par_ff[tx_chan_in];
  assign tx_idx     = dbl ? {tx_chan_in, par_sel} : {1'b0, tx_chan_in}; // RULE5
  assign frame_done = tx_valid_in && !quad && tx_chan_in == LAST_CHAN && (!dbl || par_sel);

  assign status_word = {17'h0, base48_ff, overrun_ff, cap_hit_ff, chan_count_ff,
                        !aes_dual_wire_out, !quad, rate_sel_ff};

  // one wait state: pready rises on the second access cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      pready_out <= 1'b0;
    else
      pready_out <= apb_acc & !pready_out;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end
    else if (apb_acc && !pready_out)
    begin
      pslverr_out <= !addr_ok(paddr_in);
      prdata_out  <= 32'h0000_0000;
      if (!pwrite_in)
      begin
        unique case (paddr_in)
          OFS_CTRL:   prdata_out <= {22'h0, chan_req_ff, aes_dual_req_ff, base48_ff, rate_sel_ff};
          OFS_STATUS: prdata_out <= status_word;
          OFS_CS_TX:  prdata_out <= {24'h0, cs_tx_byte0_out};
          OFS_CS_RX:  prdata_out <= {20'h0, cs_dec_ff};
          default:    prdata_out <= 32'h0000_0000;
        endcase
      end
    end
    else
    begin
      pslverr_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      rate_sel_ff     <= 2'h0;
      base48_ff       <= 1'b0;
      aes_dual_req_ff <= 1'b0;
      chan_req_ff     <= CHAN_REQ_RST;
    end
    else if (apb_wr && paddr_in == OFS_CTRL)
    begin
      rate_sel_ff     <= pwdata_in[CTRL_RATE +: 2];
      base48_ff       <= pwdata_in[CTRL_BASE48];
      aes_dual_req_ff <= pwdata_in[CTRL_AES_DUAL];
      chan_req_ff     <= pwdata_in[CTRL_CHAN +: 6];
    end
  end

  // outgoing status byte travels beside the samples, never inside them
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      cs_tx_byte0_out <= CS_TX_RST;
    else if (apb_wr && paddr_in == OFS_CS_TX)
      cs_tx_byte0_out <= pwdata_in[7:0]; // RULE11
  end

  // samples reach the AES path at the same word position in either format
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      aes_valid_out  <= 1'b0;
      aes_sample_out <= '0;
    end
    else
    begin
      aes_valid_out  <= tx_valid_in; // RULE11
      aes_sample_out <= tx_sample_in; // RULE2
    end
  end

  // dual wire only exists at double rate; quad stays single wire
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      aes_dual_wire_out <= 1'b0;
    else
      aes_dual_wire_out <= aes_dual_req_ff & dbl; // RULE8
  end

  // bus load in single-rate channels, capped at the internal limit
  assign nxt_load = dbl ? {1'b0, chan_req_ff, 1'b0} : quad ? {chan_req_ff, 2'b00} : {2'b00, chan_req_ff};

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      chan_count_ff <= 8'h00;
      cap_hit_ff    <= 1'b0;
    end
    else
    begin
      cap_hit_ff    <= nxt_load > MAX_CHAN;
      chan_count_ff <= (nxt_load > MAX_CHAN) ? MAX_CHAN : nxt_load; // RULE7
    end
  end

  always_comb
  begin
    nxt_cs_dec                   = 12'h000;
    nxt_cs_dec[DEC_PRO]          = cs_rx_in[CS_PRO]; // RULE9
    nxt_cs_dec[DEC_NONAUDIO]     = cs_rx_in[CS_NONAUDIO]; // RULE10
    if (cs_rx_in[CS_PRO])
    begin
      nxt_cs_dec[DEC_EMPH +: 3]  = cs_rx_in[CS_PRO_EMPH +: 3];
      nxt_cs_dec[DEC_LOCK]       = cs_rx_in[CS_PRO_LOCK];
      nxt_cs_dec[DEC_FS +: 2]    = cs_rx_in[CS_TOP +: 2];
    end
    else
    begin
      nxt_cs_dec[DEC_EMPH +: 3]  = cs_rx_in[CS_CON_EMPH +: 3];
      nxt_cs_dec[DEC_COPY]       = cs_rx_in[CS_CON_COPY];
      nxt_cs_dec[DEC_MODE +: 2]  = cs_rx_in[CS_TOP +: 2];
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      cs_dec_ff <= 12'h000;
    else
      cs_dec_ff <= nxt_cs_dec;
  end

  // per-channel sample parity picks even or odd slot of the pair
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || !dbl)
      tx_par_ff <= 8'h00;
    else if (tx_valid_in)
      tx_par_ff[tx_chan_in] <= ~par_sel; // RULE3
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (tx_valid_in && !quad)
      tx_work_ff[tx_idx] <= tx_sample_in; // RULE4
  end

  // hand a full frame to the link end only once it took the last one
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      tx_req_ff <= 1'b0;
    else if (frame_done && sync2_ff[2] == tx_req_ff)
    begin
      tx_hold_ff         <= tx_work_ff;
      tx_hold_ff[tx_idx] <= tx_sample_in;
      tx_req_ff          <= ~tx_req_ff;
    end
  end

  // set by a dropped frame, cleared by writing one to its status bit
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      overrun_ff <= 1'b0;
    else if (frame_done && sync2_ff[2] != tx_req_ff)
      overrun_ff <= 1'b1;
    else if (apb_wr && paddr_in == OFS_STATUS && pwdata_in[STAT_OVERRUN])
      overrun_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk_in)
  begin
    sync1_ff <= {link_ack, link_rx_tgl, link_tick_tgl};
    sync2_ff <= sync1_ff;
    sync3_ff <= sync2_ff[1:0];
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      conv_tick_out <= 1'b0;
    else
      conv_tick_out <= sync2_ff[0] ^ sync3_ff[0]; // RULE1 RULE12
  end

  // received frame is stable for a whole link frame after its toggle
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      rx_busy_ff   <= 1'b0;
      rx_ptr_ff    <= 4'h0;
      rx_valid_out <= 1'b0;
      rx_odd_ff    <= 1'b0;
      rx_chan_out  <= 3'h0;
      rx_sample_out <= '0;
    end
    else if (rx_busy_ff)
    begin
      rx_valid_out  <= 1'b1;
      rx_sample_out <= link_rx_frame[rx_ptr_ff]; // RULE13
      rx_chan_out   <= dbl ? rx_ptr_ff[3:1] : rx_ptr_ff[2:0];
      rx_odd_ff     <= dbl & rx_ptr_ff[0];
      rx_ptr_ff     <= rx_ptr_ff + 4'h1;
      rx_busy_ff    <= rx_ptr_ff != (dbl ? LAST_WORD_DBL : LAST_WORD_SGL);
    end
    else
    begin
      rx_valid_out <= 1'b0;
      rx_ptr_ff    <= 4'h0;
      rx_busy_ff   <= (sync2_ff[1] ^ sync3_ff[1]) && !quad;
    end
  end

  split_channel_link u_link (
    .link_clk_in       (link_clk_in),
    .srst_in           (srst_in),
    .tx_req_in         (tx_req_ff),
    .quad_in           (quad),
    .double_in         (dbl),
    .tx_frame_in       (tx_hold_ff),
    .opt_first_rx_in   (opt_first_rx_in),
    .opt_second_rx_in  (opt_second_rx_in),
    .tx_ack_out        (link_ack),
    .rx_tgl_out        (link_rx_tgl),
    .tick_tgl_out      (link_tick_tgl),
    .rx_frame_out      (link_rx_frame),
    .opt_first_tx_out  (opt_first_tx_out),
    .opt_second_tx_out (opt_second_tx_out),
    .opt_frame_out     (opt_frame_out)
  );

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_even_word;
    rx_valid_out && !rx_odd_ff && dbl;
  endsequence
  sequence s_odd_word;
    rx_valid_out && rx_odd_ff;
  endsequence

  a_chan_cap : assert property (chan_count_ff <= MAX_CHAN) // RULE7
    else $error("internal channel count above cap");
  a_quad_single : assert property (quad |=> !aes_dual_wire_out) // RULE8
    else $error("dual wire AES output at quad rate");
  a_quad_no_load : assert property (quad && tx_valid_in |=> $stable(tx_req_ff)) // RULE7
    else $error("optical frame loaded at quad rate");
  a_pro_decode : assert property (cs_rx_in[CS_PRO] |=> // RULE9
    cs_dec_ff[DEC_PRO] && cs_dec_ff[DEC_LOCK] == $past(cs_rx_in[CS_PRO_LOCK]) && !cs_dec_ff[DEC_COPY])
    else $error("professional status byte decoded wrongly");
  a_con_decode : assert property (!cs_rx_in[CS_PRO] |=> // RULE10
    cs_dec_ff[DEC_COPY] == $past(cs_rx_in[CS_CON_COPY]) && !cs_dec_ff[DEC_LOCK] &&
    cs_dec_ff[DEC_EMPH +: 3] == $past(cs_rx_in[CS_CON_EMPH +: 3]))
    else $error("consumer status byte decoded wrongly");
  a_even_slot : assert property (tx_valid_in && dbl && !par_sel && !frame_done |=> // RULE3
    tx_work_ff[{$past(tx_chan_in), 1'b0}] == $past(tx_sample_in))
    else $error("even sample not in first slot of pair");
  a_pair_toggle : assert property (tx_valid_in && dbl |=> // RULE3
    tx_par_ff[$past(tx_chan_in)] != $past(par_sel) || !dbl)
    else $error("slot pair parity did not advance");
  a_port_map : assert property (tx_valid_in && dbl && !frame_done |=> // RULE5
    tx_work_ff[{$past(tx_chan_in[2]), $past(tx_chan_in[1:0]), $past(par_sel)}] == $past(tx_sample_in))
    else $error("input channel mapped to wrong port slot");
  a_rx_pairs : assert property (s_even_word |=> s_odd_word and (rx_chan_out == $past(rx_chan_out))) // RULE13
    else $error("received pair not re-interleaved in order");
endmodule
`default_nettype wire

/* testbench/optical_peer.sv */
// optical_peer: far-end optical equipment that echoes each port back in frame position
// assumes the device frames its own receive side on its own transmit framing
`timescale 1ns/10ps
`default_nettype none
module optical_peer (
  input  wire logic link_clk_in,
  input  wire logic first_tx_in,
  input  wire logic second_tx_in,
  input  wire logic frame_in,
  output logic      first_rx_out,
  output logic      second_rx_out,
  output int        period_out
);
  int   gap_ff = 1000;
  logic pat_ff = 1'b0;
  logic live;
  // frame spacing seen on the wire
  always_ff @(posedge link_clk_in)
  begin
    pat_ff <= ~pat_ff;
    if (frame_in)
    begin
      gap_ff     <= 0;
      period_out <= gap_ff + 1;
    end
    else if (gap_ff < 1000)
      gap_ff <= gap_ff + 1;
  end
  // slot pairs come back in the order sent; a silent link shows a moving pattern
  assign live          = gap_ff < 200;
  assign first_rx_out  = live ? first_tx_in : pat_ff;
  assign second_rx_out = live ? second_tx_in : pat_ff;
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// testbench: register, channel-status, double and quad rate checks with an echoing peer
// assumes one wait state on the register bus and a free-running link clock
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import rate_mux_pkg::*;
  logic sys_clk_in, srst_in, link_clk_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [ADDR_W-1:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic tx_valid_in, rx_valid_out, aes_valid_out, aes_dual_wire_out, conv_tick_out, err;
  logic [2:0] tx_chan_in, rx_chan_out;
  logic [SAMPLE_W-1:0] tx_sample_in, rx_sample_out, aes_sample_out;
  logic [7:0] cs_tx_byte0_out, cs_rx_in;
  logic opt_first_rx_in, opt_second_rx_in, opt_first_tx_out, opt_second_tx_out, opt_frame_out;
  int n_errors, n_tests, n_tick, n_frm, period;
  logic cnt_on;

  double_rate_sample_multiplexer dut (.sys_clk_in, .srst_in, .link_clk_in, .paddr_in, .psel_in,
    .penable_in, .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .tx_valid_in,
    .tx_chan_in, .tx_sample_in, .rx_valid_out, .rx_chan_out, .rx_sample_out, .aes_valid_out,
    .aes_sample_out, .cs_tx_byte0_out, .aes_dual_wire_out, .cs_rx_in, .conv_tick_out,
    .opt_first_rx_in, .opt_second_rx_in, .opt_first_tx_out, .opt_second_tx_out, .opt_frame_out);
  optical_peer peer (.link_clk_in, .first_tx_in(opt_first_tx_out), .second_tx_in(opt_second_tx_out),
    .frame_in(opt_frame_out), .first_rx_out(opt_first_rx_in), .second_rx_out(opt_second_rx_in),
    .period_out(period));

  initial
  begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    link_clk_in = 1'b0;
    #3;
    forever #16 link_clk_in = ~link_clk_in;
  end
  always @(posedge sys_clk_in) if (cnt_on && conv_tick_out) n_tick++;
  always @(posedge link_clk_in) if (cnt_on && opt_frame_out) n_frm++;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= wr; paddr_in <= a; pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    // only the watchdog ends a wait for the answer
    do
      @(posedge sys_clk_in);
    while (pready_out !== 1'b1);
    rd = prdata_out; err = pslverr_out;
    psel_in <= 1'b0; penable_in <= 1'b0;
  endtask

  task automatic send(input logic [2:0] c, input logic [SAMPLE_W-1:0] s);
    @(posedge sys_clk_in);
    tx_valid_in <= 1'b1; tx_chan_in <= c; tx_sample_in <= s;
  endtask

  task automatic regs_basic;
    apb(0, OFS_CTRL, 0); chk("ctrl reset", 32'h0000_0080, rd);
    apb(0, OFS_CS_TX, 0); chk("cs_tx reset", 32'h0, rd);
    apb(0, 12'h010, 0); chk("unmapped err", 1, err); chk("unmapped data", 0, rd);
    apb(1, OFS_CS_TX, 32'h0000_00A5); apb(0, OFS_CS_TX, 0); chk("cs_tx", 32'hA5, rd);
    chk("cs_tx pin", 8'hA5, cs_tx_byte0_out);
  endtask

  // one sample per status format: sample position must not move
  task automatic cs_decode(input logic [7:0] cs, input logic [31:0] exp, input logic [23:0] s);
    cs_rx_in <= cs;
    send(3'h2, s);
    @(posedge sys_clk_in);
    tx_valid_in <= 1'b0;
    @(posedge sys_clk_in);
    chk("aes valid", 1, aes_valid_out);
    chk("aes sample", s, aes_sample_out);
    apb(0, OFS_CS_RX, 0); chk("cs decode", exp, rd);
  endtask

  // window of 51200 ns holds 8 or 9 link frames of 6144 ns
  task automatic rate_window(input int mul, input logic optical);
    n_tick = 0; n_frm = 0; cnt_on = 1'b1;
    repeat (6400) @(posedge sys_clk_in);
    cnt_on = 1'b0;
    chk("ticks per window", 1, n_tick >= 8 * mul && n_tick <= 9 * mul);
    chk("frames per window", 32'(optical), n_frm >= 8 && n_frm <= 9);
  endtask

  task automatic double_loop;
    int i;
    apb(1, OFS_CTRL, 32'h81);
    apb(0, OFS_STATUS, 0); chk("status double", 32'h10D, rd);
    rate_window(2, 1'b1);
    chk("frame period", 192, period);
    for (i = 0; i < 16; i++)
      send(3'(i / 2), 24'hA50000 | 24'(i * 'h111));
    @(posedge sys_clk_in);
    tx_valid_in <= 1'b0;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge sys_clk_in);
      if (rx_valid_out === 1'b1 && rx_sample_out === 24'hA50000)
        break;
    end
    chk("rx first", 24'hA50000, rx_sample_out);
    for (i = 1; i < 16; i++)
    begin
      @(posedge sys_clk_in);
      chk("rx valid", 1, rx_valid_out);
      chk("rx chan", i / 2, rx_chan_out);
      chk("rx sample", 24'hA50000 | 24'(i * 'h111), rx_sample_out);
    end
  endtask

  // three frames in quick succession: at most one can be taken per link frame
  task automatic overrun_clear;
    int i;
    for (i = 0; i < 48; i++)
      send(3'(i % 16 / 2), 24'(i));
    @(posedge sys_clk_in);
    tx_valid_in <= 1'b0;
    apb(0, OFS_STATUS, 0); chk("overrun set", 1, rd[STAT_OVERRUN]);
    apb(1, OFS_STATUS, 32'h0000_2000);
    apb(0, OFS_STATUS, 0); chk("overrun clear", 0, rd[STAT_OVERRUN]);
  endtask

  task automatic quad_mode;
    apb(1, OFS_CTRL, 32'h109);
    repeat (3) @(posedge sys_clk_in);
    chk("dual wire double", 1, aes_dual_wire_out);
    apb(1, OFS_CTRL, 32'h10A);
    repeat (3) @(posedge sys_clk_in);
    chk("dual wire quad", 0, aes_dual_wire_out);
    apb(0, OFS_STATUS, 0); chk("status quad", 32'h130A, rd);
    send(3'h7, 24'h000001);
    @(posedge sys_clk_in);
    tx_valid_in <= 1'b0;
    rate_window(1, 1'b0);
    chk("no optical frames", 0, n_frm);
  endtask

  task automatic summarize;
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    n_errors++;
    summarize();
  end

  initial
  begin
    n_errors = 0; n_tests = 0; cnt_on = 1'b0; srst_in = 1'b1;
    psel_in = 1'b0; penable_in = 1'b0; pwrite_in = 1'b0; paddr_in = '0; pwdata_in = '0;
    tx_valid_in = 1'b0; tx_chan_in = '0; tx_sample_in = '0; cs_rx_in = 8'h00;
    repeat (16) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    regs_basic();
    cs_decode(8'hED, 32'h32D, 24'h123456);
    cs_decode(8'h6E, 32'h456, 24'h123456);
    rate_window(1, 1'b1);
    double_loop();
    overrun_clear();
    quad_mode();
    summarize();
  end
endmodule
`default_nettype wire
